/* File: logic/bus_halt_pkg.sv */
package bus_halt_pkg;

    // ==========================================================
    // bus widths and reset values
    // ==========================================================
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    // ==========================================================
    // restart stretch timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESTART_HOLD_NS = 2000;
    localparam int RESTART_CYCLES =
        (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 8;
    localparam logic [RST_CNT_W-1:0] RESTART_LOAD =
        RST_CNT_W'(RESTART_CYCLES);
    localparam logic [RST_CNT_W-1:0] RST_CNT_ZERO = 8'h00;

    // ==========================================================
    // processor run state
    // ==========================================================
    typedef enum logic [0:0] {
        MODE_HALTED = 1'b0,
        MODE_RUNNING = 1'b1
    } run_mode_t;

endpackage

/* File: logic/bus_halt_ctrl.sv */
// Notes on behaviour
// - go high lets the processor run
// - go low halts, level sensitive
// - halt only at instruction end or on board reset
// - halted: bus free high, valid cycle low
// - halted: address lines released, direction line stays driven
// - restart line outputs board reset
// - external low on restart resets board
// - direction output shows transfer direction
// - read high, write low, idle read
// - halted keeps direction at read
// - address lines carry processor address
`timescale 1ns/1ps

module bus_halt_ctrl (
    input wire logic CLK, // 50 MHz system clock
    input wire logic RESET, // synchronous, active high
    input wire logic GO, // run/halt level, high runs
    input wire logic RESTART_IN, // restart pin level, low restarts
    input wire logic CORE_VALID, // core requests a bus transfer
    input wire logic CORE_RW, // core direction, high reads
    input wire logic [bus_halt_pkg::ADDR_W-1:0] CORE_ADDR, // core address
    input wire logic CORE_INSTR_END, // last cycle of an instruction
    output logic CORE_RUN, // core may advance
    output logic BOARD_RESET, // board-wide reset, active high
    output logic RESTART_OUT, // restart pin drive value, always low
    output logic RESTART_OE, // restart pin driven low
    output logic [bus_halt_pkg::ADDR_W-1:0] ADDR_O, // address lines
    output logic ADDR_OE, // address lines driven
    output logic RW_O, // direction, high reads
    output logic RW_OE, // direction line driven
    output logic VALID_MEMORY_CYCLE, // valid access qualifier
    output logic BUS_FREE // bus available indicator
);
    import bus_halt_pkg::*;

    typedef struct packed {
        run_mode_t mode;
        logic [RST_CNT_W-1:0] cnt;
        logic board_reset;
        logic drive;
        logic [ADDR_W-1:0] addr;
        logic addr_oe;
        logic rw;
        logic valid_memory_cycle;
        logic bus_free;
        logic rw_oe;
        logic restart_val;
    } state_t;

    state_t s;
    state_t next_s;
    logic keep_run;

    // ==========================================================
    // decode
    // ==========================================================
    // go low only counts once the current instruction is done
    function automatic logic halt_point(input logic go_lvl,
        input logic instr_end);
        return !go_lvl && instr_end;
    endfunction

    // ==========================================================
    // next state
    // ==========================================================
    always_comb begin
        next_s = s;
        keep_run = 1'b0;
        if (RESET) begin
            next_s.mode = MODE_HALTED;
            next_s.cnt = RESTART_LOAD;
            next_s.board_reset = 1'b1;
            next_s.drive = 1'b1;
            next_s.addr = ADDR_RESET;
            next_s.addr_oe = 1'b0;
            next_s.rw = RW_READ;
            next_s.valid_memory_cycle = 1'b0;
            next_s.bus_free = 1'b1;
            next_s.rw_oe = 1'b1;
            next_s.restart_val = 1'b0;
        end else begin
            // pin sensed only while released, else our own drive retriggers
            if (!s.drive && !RESTART_IN) begin
                next_s.cnt = RESTART_LOAD;
                next_s.board_reset = 1'b1;
                next_s.drive = 1'b1;
            end else if (s.cnt != RST_CNT_ZERO) begin
                // fixed stretch; a short external pulse gets the full span
                next_s.cnt = s.cnt - RST_CNT_W'(1);
            end else begin
                next_s.board_reset = 1'b0;
                next_s.drive = 1'b0;
            end
            if (next_s.board_reset) begin
                next_s.mode = MODE_HALTED;
            end else if (s.mode == MODE_HALTED) begin
                if (GO) begin
                    next_s.mode = MODE_RUNNING;
                end
            end else if (halt_point(GO, CORE_INSTR_END)) begin
                next_s.mode = MODE_HALTED;
            end
            keep_run = (next_s.mode == MODE_RUNNING);
            // transfer outputs; idle and halt rest at read
            // a request in the halting cycle is dropped, core must retry
            next_s.valid_memory_cycle = keep_run && s.mode == MODE_RUNNING
                && CORE_VALID;
            next_s.rw = next_s.valid_memory_cycle ? CORE_RW : RW_READ;
            next_s.addr = keep_run ? CORE_ADDR : s.addr;
            next_s.addr_oe = keep_run;
            next_s.bus_free = !keep_run;
        end
    end

    always_ff @(posedge CLK) begin
        s <= next_s;
    end

    // ==========================================================
    // outputs
    // ==========================================================
    always_comb begin
        CORE_RUN = (s.mode == MODE_RUNNING);
        BOARD_RESET = s.board_reset;
        RESTART_OUT = s.restart_val;
        RESTART_OE = s.drive;
        ADDR_O = s.addr;
        ADDR_OE = s.addr_oe;
        // direction stays driven when halted so the read level holds
        RW_O = s.rw;
        RW_OE = s.rw_oe;
        VALID_MEMORY_CYCLE = s.valid_memory_cycle;
        BUS_FREE = s.bus_free;
    end

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    a_resume_on_go: assert property (
        !CORE_RUN && GO && !BOARD_RESET && RESTART_IN
            && $past(RESTART_IN) |=> CORE_RUN
    ) else $error("no resume after go rose");

    a_halt_at_end: assert property (
        CORE_RUN && !GO && CORE_INSTR_END |=> !CORE_RUN
    ) else $error("no halt at instruction end");

    a_no_mid_halt: assert property (
        CORE_RUN && !CORE_INSTR_END && !BOARD_RESET
            && (RESTART_OE || RESTART_IN) |=> CORE_RUN
    ) else $error("halted inside an instruction");

    a_halted_bus_free: assert property (
        !CORE_RUN |-> BUS_FREE && !VALID_MEMORY_CYCLE
    ) else $error("halted bus not free");

    a_halted_float: assert property (
        !CORE_RUN |-> !ADDR_OE
    ) else $error("address driven while halted");

    a_restart_carries: assert property (
        RESTART_OE |-> BOARD_RESET && !RESTART_OUT
    ) else $error("restart drive without board reset");

    a_ext_restart: assert property (
        !RESTART_OE && !RESTART_IN |=> BOARD_RESET && RESTART_OE
            ##1 !CORE_RUN
    ) else $error("external restart ignored");

    a_transfer_out: assert property (
        CORE_RUN && CORE_VALID && !halt_point(GO, CORE_INSTR_END)
            && RESTART_IN |=> VALID_MEMORY_CYCLE
            && ADDR_OE && ADDR_O == $past(CORE_ADDR)
            && RW_O == $past(CORE_RW)
    ) else $error("transfer not presented on bus");

    a_idle_read: assert property (
        !VALID_MEMORY_CYCLE |-> RW_O == RW_READ && RW_OE
    ) else $error("idle direction not read");

    a_halted_read: assert property (
        !CORE_RUN |-> RW_O == RW_READ
    ) else $error("halted direction not read");

    a_run_needs_go: assert property (
        $rose(CORE_RUN) |-> $past(GO)
    ) else $error("core started without go");

    a_halt_persists: assert property (
        !CORE_RUN && !GO |=> !CORE_RUN
    ) else $error("core left halt while go low");

    a_stop_boundary: assert property (
        $fell(CORE_RUN) |-> $past(CORE_INSTR_END) || BOARD_RESET
    ) else $error("core stopped off an instruction end");

    a_halt_drops_req: assert property (
        !CORE_RUN |=> !VALID_MEMORY_CYCLE
    ) else $error("access issued from halted state");

    a_run_drives_addr: assert property (
        CORE_RUN |-> ADDR_OE && !BUS_FREE
    ) else $error("running without address drive");

    a_write_level: assert property (
        VALID_MEMORY_CYCLE |-> RW_O == $past(CORE_RW)
    ) else $error("direction differs from request");

    a_pin_follows: assert property (
        BOARD_RESET |-> RESTART_OE
    ) else $error("board reset not on restart line");

    a_stretch_min: assert property (
        $rose(RESTART_OE) |-> RESTART_OE [*8]
    ) else $error("restart drive too short");

endmodule

/* File: dv/far_modules.sv */
`timescale 1ns/1ps

module far_modules (
    input wire logic restart_oe, // board pulls restart line
    input wire logic restart_out, // board drive value
    input wire logic switch_closed, // external switch to ground
    output logic restart_wire // restart line level
);
    // =====
    // wired restart line
    // =====
    // pull-up: line only drops when someone grounds it
    assign restart_wire = (restart_oe ? restart_out : 1'b1)
        & !switch_closed;
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps

module tb;
    import bus_halt_pkg::*;
    logic clk = 0, reset = 1, go = 0, sw = 0, valid = 0, rw = 1, iend = 0;
    logic [ADDR_W-1:0] addr = 16'h0000;
    logic [ADDR_W-1:0] ao;
    logic run, brst, rout, roe, aoe, rwo, rwoe, vmc, bfree, rwire;
    logic [ADDR_W:0] q[$];
    logic [ADDR_W:0] e;
    int n_mismatch = 0, total_checks = 0, seed = 92708, i;
    // =====
    // clock, watchdog, instances
    // =====
    initial forever #10 clk = ~clk;
    initial begin
        #(4000 * 20);
        n_mismatch++;
        results;
    end
    bus_halt_ctrl dut (.CLK(clk), .RESET(reset), .GO(go),
        .RESTART_IN(rwire), .CORE_VALID(valid), .CORE_RW(rw),
        .CORE_ADDR(addr), .CORE_INSTR_END(iend), .CORE_RUN(run),
        .BOARD_RESET(brst), .RESTART_OUT(rout), .RESTART_OE(roe),
        .ADDR_O(ao), .ADDR_OE(aoe), .RW_O(rwo), .RW_OE(rwoe),
        .VALID_MEMORY_CYCLE(vmc), .BUS_FREE(bfree));
    far_modules far (.restart_oe(roe), .restart_out(rout),
        .switch_closed(sw), .restart_wire(rwire));
    // =====
    // tasks
    // =====
    task chk(input string nm, input logic [ADDR_W:0] ex,
        input logic [ADDR_W:0] got);
        total_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, ex, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // =====
    // monitor: oldest note against each valid cycle
    // =====
    always @(negedge clk) begin
        if (vmc === 1'b1) begin
            e = q.size() ? q.pop_front() : 'x;
            chk("xfer", e, {rwo, ao});
        end else if (run === 1'b1) begin
            chk("rw idle", RW_READ, rwo);
        end
    end
    // =====
    // main sequence
    // =====
    initial begin
        cyc(6);
        reset = 0;
        for (i = 0; i < 300 && brst !== 1'b0; i++) cyc(1);
        chk("free", 3'b100, {bfree, vmc, aoe});
        go = 1;
        cyc(2);
        chk("run", 3'b101, {run, bfree, aoe});
        for (i = 0; i < 40; i++) begin
            valid = $random(seed);
            rw = $random(seed);
            addr = $random(seed);
            iend = $random(seed);
            if (valid) q.push_back({rw, addr});
            cyc(1);
        end
        // low go mid instruction must not stop the core yet
        {go, iend, valid} = 3'b000;
        cyc(3);
        chk("mid instr", 1, run);
        {iend, valid, rw} = 3'b110;
        cyc(1);
        iend = 0;
        chk("halt", 6'b010011, {run, bfree, vmc, aoe, rwo, rwoe});
        cyc(4);
        chk("hold", 6'b010011, {run, bfree, vmc, aoe, rwo, rwoe});
        {go, valid} = 2'b10;
        sw = 1;
        cyc(1);
        sw = 0;
        chk("restart", 4'b1100, {brst, roe, rout, run});
        for (i = 0; i < 300 && brst !== 1'b0; i++) cyc(1);
        chk("stretch", RESTART_CYCLES + 1, i);
        cyc(2);
        chk("rerun", 1, run);
        chk("left", 0, q.size());
        results;
    end
endmodule
